// file: core/srsc_pkg.sv
// Package of constants and types for the switch reset and strap control block.
package srsc_pkg;
    // ---------------------------------------------------------------
    // Register map (word index on the plain register port)
    // ---------------------------------------------------------------
    localparam logic [3:0] ADDR_SWITCH_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STRAP_STATUS = 4'h1;
    localparam logic [3:0] ADDR_UP_LINK_STATUS = 4'h2;
    localparam logic [3:0] ADDR_DN_LINK_STATUS = 4'h3;
    localparam logic [3:0] ADDR_GPIO_FUNC = 4'h4;
    localparam logic [3:0] ADDR_GPIO_OUT = 4'h5;
    localparam logic [3:0] ADDR_GPIO_DIR = 4'h6;
    localparam logic [3:0] ADDR_GPIO_IN = 4'h7;
    localparam logic [3:0] ADDR_PORT_RESET = 4'h8;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTL_HOLD_BIT = 0;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_SLOW_BIT = 3;
    localparam int ST_RUN_BIT = 4;
    localparam int ST_EEPROM_BIT = 5;
    localparam int ST_RSVD_BIT = 6;
    localparam int LSTS_SLOT_CLK_BIT = 12;
    localparam int GPIO_P2_BIT = 0;
    localparam int GPIO_P4_BIT = 1;
    localparam int GPIO_P6_BIT = 11;

    // ---------------------------------------------------------------
    // Modes and timing
    // ---------------------------------------------------------------
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_EEPROM = 3'h1;
    localparam int CLK_HZ = 25_000_000;
    localparam int BUS_SLOW_HZ = 100_000;
    localparam int BUS_FAST_HZ = 400_000;
    localparam int SLOW_DIV = CLK_HZ / (2 * BUS_SLOW_HZ);
    localparam int FAST_DIV = CLK_HZ / (2 * BUS_FAST_HZ);
    localparam int RESET_SEQ_CYCLES = 16;
    localparam logic [15:0] GPIO_FUNC_RESET = 16'h0000;

    typedef enum logic [3:0] {
        ST_RESET = 4'b0001,
        ST_SEQ = 4'b0010,
        ST_HOLD = 4'b0100,
        ST_RUN = 4'b1000
    } srsc_state_e;

    typedef struct packed {
        logic [2:0] mode;
        logic slow;
        logic dnCommonClk;
        logic upCommonClk;
        logic holdReq;
    } srsc_strap_s;
endpackage

// file: core/srsc_sync3.sv
// Three-stage pin synchroniser with agreement of the last two stages.
`timescale 1ns/1ps
module srsc_sync3 #(
    parameter int WIDTH = 1,
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] s1Q;
    logic [WIDTH-1:0] s2Q;
    logic [WIDTH-1:0] s3Q;
    logic [WIDTH-1:0] outQ;
    wire [WIDTH-1:0] agree = ~(s2Q ^ s3Q);
    wire [WIDTH-1:0] outD = (agree & s2Q) | (~agree & outQ);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1Q <= {WIDTH{RESET_VAL}};
            s2Q <= {WIDTH{RESET_VAL}};
            s3Q <= {WIDTH{RESET_VAL}};
            outQ <= {WIDTH{RESET_VAL}};
        end else begin
            s1Q <= pinIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
            outQ <= outD;
        end
    end

    assign syncOut = outQ;
endmodule

// file: core/srsc_top.sv
// Reset, strap capture, reset-halt and reset-output logic of a four-port switch.
// Contract
// - Fundamental reset clears logic, resets all ports.
// - Halt strap holds device after reset sequence.
// - Halt ends only when master clears bit.
// - Mode strap: 0 normal, 1 EEPROM, rest reserved.
// - Slow strap picks 100 or 400 kHz.
// - Downstream strap seeds downstream slot clock bits.
// - Upstream strap seeds upstream slot clock bit.
// - Test data output floats unless shifting.
// - Test reset asynchronously resets test controller.
// - Pin 11 offers port 6 reset output.
// - Pins 0 and 1 offer port 2/4 resets.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
module srsc_top #(
    parameter int GPIO_WIDTH = 16,
    parameter int DN_PORTS = 3,
    parameter int SEQ_CYCLES = srsc_pkg::RESET_SEQ_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic fundamentalResetN,
    input wire logic holdAfterReset,
    input wire logic [2:0] switchModeSelect,
    input wire logic masterBusSlowSelect,
    input wire logic commonClockDownstreamStrap,
    input wire logic commonClockUpstreamStrap,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [31:0] regRdData,
    input wire logic [GPIO_WIDTH-1:0] gpioIn,
    output logic [GPIO_WIDTH-1:0] gpioOut,
    output logic [GPIO_WIDTH-1:0] gpioOeN,
    output logic coreResetN,
    output logic [3:0] portResetN,
    output logic eepromInitReq,
    output logic masterBusTick,
    output logic smbusEnable,
    input wire logic testClk,
    input wire logic testResetN,
    input wire logic testShiftData,
    input wire logic testShiftActive,
    output logic testDataOut,
    output logic testDataOeN
);
    // ---------------------------------------------------------------
    // Parameter checks
    // ---------------------------------------------------------------
    if (GPIO_WIDTH <= srsc_pkg::GPIO_P6_BIT || GPIO_WIDTH > 32) begin : g_bad_width
        $error("GPIO_WIDTH must be between 12 and 32");
    end
    if (DN_PORTS != 3) begin : g_bad_ports
        $error("DN_PORTS must be 3");
    end
    if (SEQ_CYCLES < 1 || SEQ_CYCLES > 255) begin : g_bad_seq
        $error("SEQ_CYCLES must be between 1 and 255");
    end

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic perstSync;
    srsc_pkg::srsc_strap_s strapSync;
    logic [GPIO_WIDTH-1:0] gpioSync;

    srsc_sync3 #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_perst (
        .clk(clk),
        .rst(rst),
        .pinIn(fundamentalResetN),
        .syncOut(perstSync)
    );
    srsc_sync3 #(.WIDTH(7), .RESET_VAL(1'b0)) u_sync_strap (
        .clk(clk),
        .rst(rst),
        .pinIn({switchModeSelect, masterBusSlowSelect, commonClockDownstreamStrap,
                commonClockUpstreamStrap, holdAfterReset}),
        .syncOut(strapSync)
    );
    srsc_sync3 #(.WIDTH(GPIO_WIDTH), .RESET_VAL(1'b1)) u_sync_gpio (
        .clk(clk),
        .rst(rst),
        .pinIn(gpioIn),
        .syncOut(gpioSync)
    );

    // ---------------------------------------------------------------
    // Reset sequencer
    // ---------------------------------------------------------------
    srsc_pkg::srsc_state_e stateQ, stateD;
    logic [7:0] seqCntQ;
    logic perstPrevQ;
    srsc_pkg::srsc_strap_s strapQ;
    logic holdBitQ;

    wire inReset = ~perstSync;
    wire perstRelease = perstSync & ~perstPrevQ;

    wire seqDone = (seqCntQ == 8'(SEQ_CYCLES - 1));
    wire regWrCtl = regWrEn && regAddr == srsc_pkg::ADDR_SWITCH_CONTROL;
    wire holdClear = regWrCtl && !regWrData[srsc_pkg::CTL_HOLD_BIT];

    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            srsc_pkg::ST_RESET: begin
                if (perstRelease) begin
                    stateD = srsc_pkg::ST_SEQ;
                end
            end
            srsc_pkg::ST_SEQ: begin
                if (seqDone) begin
                    stateD = holdBitQ ? srsc_pkg::ST_HOLD : srsc_pkg::ST_RUN;
                end
            end
            srsc_pkg::ST_HOLD: begin
                if (!holdBitQ) begin
                    stateD = srsc_pkg::ST_RUN;
                end
            end
            srsc_pkg::ST_RUN: begin
                stateD = srsc_pkg::ST_RUN;
            end
            default: begin
                stateD = srsc_pkg::ST_RESET;
            end
        endcase
        if (inReset) begin
            stateD = srsc_pkg::ST_RESET;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stateQ <= srsc_pkg::ST_RESET;
            seqCntQ <= 8'h00;
            perstPrevQ <= 1'b0;
        end else begin
            stateQ <= stateD;
            perstPrevQ <= perstSync;
            seqCntQ <= (stateQ == srsc_pkg::ST_SEQ) ? seqCntQ + 8'h01 : 8'h00;
        end
    end

    // Straps are caught on the release edge and then frozen, so later pin changes are ignored.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strapQ <= '0;
        end else if (perstRelease) begin
            strapQ <= strapSync;
        end
    end

    // Hold bit: set from the strap at release; the clear written by software wins afterwards.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            holdBitQ <= 1'b0;
        end else if (inReset) begin
            holdBitQ <= 1'b0;
        end else if (perstRelease) begin
            holdBitQ <= strapSync.holdReq;
        end else if (holdClear) begin
            holdBitQ <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Mode decode and master bus rate
    // ---------------------------------------------------------------
    wire running = (stateQ == srsc_pkg::ST_RUN);
    wire modeEeprom = (strapQ.mode == srsc_pkg::MODE_EEPROM);
    wire modeRsvd = (strapQ.mode != srsc_pkg::MODE_NORMAL) && !modeEeprom;

    wire [9:0] divLimit = strapQ.slow ? 10'(srsc_pkg::SLOW_DIV - 1) : 10'(srsc_pkg::FAST_DIV - 1);
    logic [9:0] divCntQ;
    wire divWrap = (divCntQ >= divLimit);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divCntQ <= 10'h000;
        end else if (inReset || divWrap) begin
            divCntQ <= 10'h000;
        end else begin
            divCntQ <= divCntQ + 10'h001;
        end
    end

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic upSlotClkQ;
    logic [DN_PORTS-1:0] dnSlotClkQ;
    logic [GPIO_WIDTH-1:0] gpioFuncQ, gpioOutRegQ, gpioDirQ;
    logic [3:0] swPortRstQ;
    logic seedQ;

    wire wrUp = regWrEn && regAddr == srsc_pkg::ADDR_UP_LINK_STATUS;
    wire wrDn = regWrEn && regAddr == srsc_pkg::ADDR_DN_LINK_STATUS;

    wire wrFunc = regWrEn && regAddr == srsc_pkg::ADDR_GPIO_FUNC;
    wire wrOut = regWrEn && regAddr == srsc_pkg::ADDR_GPIO_OUT;
    wire wrDir = regWrEn && regAddr == srsc_pkg::ADDR_GPIO_DIR;
    wire wrPrst = regWrEn && regAddr == srsc_pkg::ADDR_PORT_RESET;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seedQ <= 1'b0;
            upSlotClkQ <= 1'b0;
            dnSlotClkQ <= '0;
        end else begin
            seedQ <= perstRelease;
            // Seeding waits a cycle for strapQ, so a write in that cycle is lost.
            if (seedQ) begin
                upSlotClkQ <= strapQ.upCommonClk;
                dnSlotClkQ <= {DN_PORTS{strapQ.dnCommonClk}};
            end else begin
                if (wrUp) begin
                    upSlotClkQ <= regWrData[srsc_pkg::LSTS_SLOT_CLK_BIT];
                end
                if (wrDn) begin
                    dnSlotClkQ <= regWrData[DN_PORTS-1:0];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gpioFuncQ <= srsc_pkg::GPIO_FUNC_RESET[GPIO_WIDTH-1:0];
            gpioOutRegQ <= '0;
            gpioDirQ <= '0;
            swPortRstQ <= 4'h0;
        end else if (inReset) begin
            gpioFuncQ <= srsc_pkg::GPIO_FUNC_RESET[GPIO_WIDTH-1:0];
            gpioOutRegQ <= '0;
            gpioDirQ <= '0;
            swPortRstQ <= 4'h0;
        end else begin
            if (wrFunc) begin
                gpioFuncQ <= regWrData[GPIO_WIDTH-1:0];
            end
            if (wrOut) begin
                gpioOutRegQ <= regWrData[GPIO_WIDTH-1:0];
            end
            if (wrDir) begin
                gpioDirQ <= regWrData[GPIO_WIDTH-1:0];
            end
            if (wrPrst) begin
                swPortRstQ <= regWrData[3:0];
            end
        end
    end

    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (regAddr)
            srsc_pkg::ADDR_SWITCH_CONTROL: rdMux[srsc_pkg::CTL_HOLD_BIT] = holdBitQ;
            srsc_pkg::ADDR_STRAP_STATUS: begin
                rdMux[srsc_pkg::ST_MODE_LSB +: 3] = strapQ.mode;
                rdMux[srsc_pkg::ST_SLOW_BIT] = strapQ.slow;
                rdMux[srsc_pkg::ST_RUN_BIT] = running;
                rdMux[srsc_pkg::ST_EEPROM_BIT] = modeEeprom;
                rdMux[srsc_pkg::ST_RSVD_BIT] = modeRsvd;
            end
            srsc_pkg::ADDR_UP_LINK_STATUS: rdMux[srsc_pkg::LSTS_SLOT_CLK_BIT] = upSlotClkQ;
            srsc_pkg::ADDR_DN_LINK_STATUS: rdMux[DN_PORTS-1:0] = dnSlotClkQ;
            srsc_pkg::ADDR_GPIO_FUNC: rdMux[GPIO_WIDTH-1:0] = gpioFuncQ;
            srsc_pkg::ADDR_GPIO_OUT: rdMux[GPIO_WIDTH-1:0] = gpioOutRegQ;
            srsc_pkg::ADDR_GPIO_DIR: rdMux[GPIO_WIDTH-1:0] = gpioDirQ;
            srsc_pkg::ADDR_GPIO_IN: rdMux[GPIO_WIDTH-1:0] = gpioSync;
            srsc_pkg::ADDR_PORT_RESET: rdMux[3:0] = swPortRstQ;
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // ---------------------------------------------------------------
    // Port resets and pin outputs
    // ---------------------------------------------------------------
    // Port order in portResetN: 0 upstream, 1 port 2, 2 port 4, 3 port 6.
    // Gating by inReset drops these in the cycle reset arrives, not a cycle later with the state.
    wire runLive = running && !inReset;
    wire busLive = !inReset && (stateQ == srsc_pkg::ST_HOLD || running);
    wire eepromD = (stateQ == srsc_pkg::ST_SEQ) && seqDone && modeEeprom;
    wire tickD = divWrap && !inReset;
    wire [3:0] portRstD = runLive ? ~swPortRstQ : 4'h0;

    logic [GPIO_WIDTH-1:0] altMask, altVal, pinOutD, pinOeND;
    always_comb begin
        altMask = '0;
        altVal = '0;
        altMask[srsc_pkg::GPIO_P2_BIT] = gpioFuncQ[srsc_pkg::GPIO_P2_BIT];
        altMask[srsc_pkg::GPIO_P4_BIT] = gpioFuncQ[srsc_pkg::GPIO_P4_BIT];
        altMask[srsc_pkg::GPIO_P6_BIT] = gpioFuncQ[srsc_pkg::GPIO_P6_BIT];
        altVal[srsc_pkg::GPIO_P2_BIT] = portRstD[1];
        altVal[srsc_pkg::GPIO_P4_BIT] = portRstD[2];
        altVal[srsc_pkg::GPIO_P6_BIT] = portRstD[3];
        pinOutD = (altMask & altVal) | (~altMask & gpioOutRegQ);
        pinOeND = ~(altMask | gpioDirQ);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= 32'h0000_0000;
            coreResetN <= 1'b0;
            portResetN <= 4'h0;
            eepromInitReq <= 1'b0;
            masterBusTick <= 1'b0;
            smbusEnable <= 1'b0;
            gpioOut <= '0;
            gpioOeN <= '1;
        end else begin
            regRdData <= regRdEn ? rdMux : 32'h0000_0000;
            coreResetN <= runLive;
            portResetN <= portRstD;
            eepromInitReq <= eepromD;
            masterBusTick <= tickD;
            smbusEnable <= busLive;
            gpioOut <= pinOutD;
            gpioOeN <= pinOeND;
        end
    end

    // ---------------------------------------------------------------
    // Test data output, on the test clock with its own asynchronous reset
    // ---------------------------------------------------------------
    // The test reset must be held low in functional use so this stays floated.
    always_ff @(posedge testClk or negedge testResetN) begin
        if (!testResetN) begin
            testDataOut <= 1'b0;
            testDataOeN <= 1'b1;
        end else begin
            testDataOut <= testShiftData;
            testDataOeN <= !testShiftActive;
        end
    end
endmodule

// file: tb/srsc_asserts.sv
// Concurrent checks on the ports of the reset and strap control block.
`timescale 1ns/1ps
module srsc_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic fundamentalResetN,
    input wire logic [2:0] switchModeSelect,
    input wire logic masterBusSlowSelect,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrEn,
    input wire logic coreResetN,
    input wire logic [3:0] portResetN,
    input wire logic eepromInitReq,
    input wire logic masterBusTick,
    input wire logic smbusEnable,
    input wire logic testResetN,
    input wire logic testShiftActive,
    input wire logic testDataOut,
    input wire logic testDataOeN
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    // A clearing write while halted; halt still shows for two cycles after it.
    wire clrReq = smbusEnable && !coreResetN && regWrEn && regAddr == srsc_pkg::ADDR_SWITCH_CONTROL
        && !regWrData[srsc_pkg::CTL_HOLD_BIT];
    logic [1:0] clrSeen_q;
    logic seen_q;
    logic [7:0] gap_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clrSeen_q <= 2'h0;
            seen_q <= 1'b0;
            gap_q <= 8'h00;
        end else begin
            clrSeen_q <= {clrSeen_q[0], clrReq};
            seen_q <= smbusEnable && fundamentalResetN && (seen_q || masterBusTick);
            gap_q <= masterBusTick ? 8'h01 : gap_q + 8'h01;
        end
    end

    resetHolds_a: assert property (!fundamentalResetN [*6] |-> !coreResetN && portResetN == 4'h0)
        else $error("reset released early");
    busQuiet_a: assert property (!fundamentalResetN [*6] |-> !smbusEnable)
        else $error("bus on in reset");
    runHasBus_a: assert property (coreResetN |-> smbusEnable)
        else $error("run without bus");
    haltStays_a: assert property (smbusEnable && !coreResetN && !clrReq && !clrSeen_q |=> !coreResetN)
        else $error("halt left early");
    haltRelease_a: assert property (clrReq && fundamentalResetN |-> ##3 coreResetN && portResetN == 4'hf)
        else $error("halt not left");
    tdoFloat_a: assert property (!testShiftActive [*8] |-> testDataOeN)
        else $error("test data driven idle");
    testReset_a: assert property (!testResetN |-> testDataOeN && !testDataOut)
        else $error("test out in reset");
    tickSpan_a: assert property (fundamentalResetN && masterBusTick && seen_q |-> masterBusSlowSelect
        ? int'(gap_q) inside {[srsc_pkg::SLOW_DIV:srsc_pkg::SLOW_DIV + 1]}
        : int'(gap_q) inside {[srsc_pkg::FAST_DIV:srsc_pkg::FAST_DIV + 1]})
        else $error("tick spacing wrong");
    eepromPulse_a: assert property (eepromInitReq |-> switchModeSelect == srsc_pkg::MODE_EEPROM ##1 !eepromInitReq)
        else $error("stray eeprom request");
endmodule

bind srsc_top srsc_asserts srsc_asserts_inst (.clk, .rst, .fundamentalResetN, .switchModeSelect, .masterBusSlowSelect,
    .regAddr, .regWrData, .regWrEn, .coreResetN, .portResetN, .eepromInitReq, .masterBusTick, .smbusEnable,
    .testResetN, .testShiftActive, .testDataOut, .testDataOeN);

// file: tb/srsc_board.sv
// Board reset logic and configuration master driving the block's pins and register port.
`timescale 1ns/1ps
module srsc_board (
    input wire logic clk,
    output logic fundamentalResetN,
    output logic holdAfterReset,
    output logic [2:0] switchModeSelect,
    output logic masterBusSlowSelect,
    output logic commonClockDownstreamStrap,
    output logic commonClockUpstreamStrap,
    output logic testResetN,
    output logic [3:0] regAddr,
    output logic [31:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [31:0] regRdData
);
    initial begin
        fundamentalResetN = 1'b0;
        {holdAfterReset, switchModeSelect, masterBusSlowSelect} = 5'h00;
        {commonClockDownstreamStrap, commonClockUpstreamStrap} = 2'h0;
        testResetN = 1'b0;
        {regAddr, regWrData, regWrEn, regRdEn} = 38'h0;
    end
    // Straps move only while reset is low, so they are steady from every release on.
    task automatic enter(input srsc_pkg::srsc_strap_s s);
        @(posedge clk);
        fundamentalResetN <= 1'b0;
        {switchModeSelect, masterBusSlowSelect} <= {s.mode, s.slow};
        {commonClockDownstreamStrap, commonClockUpstreamStrap} <= {s.dnCommonClk, s.upCommonClk};
        holdAfterReset <= s.holdReq;
    endtask
    task automatic leave();
        @(posedge clk);
        fundamentalResetN <= 1'b1;
    endtask
    task automatic setTest(input logic v);
        @(posedge clk);
        testResetN <= v;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        {regAddr, regWrData, regWrEn} <= {a, d, 1'b1};
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        {regAddr, regRdEn} <= {a, 1'b1};
        @(posedge clk);
        regRdEn <= 1'b0;
        #1 d = regRdData;
    endtask
endmodule

// file: tb/srsc_tb_top.sv
// Self-checking bench of the switch reset and strap control block.
`timescale 1ns/1ps
module srsc_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic testClk = 1'b0;
    logic testShiftData = 1'b0;
    logic testShiftActive = 1'b0;
    logic fundamentalResetN, holdAfterReset, masterBusSlowSelect, testResetN, regWrEn, regRdEn;
    logic commonClockDownstreamStrap, commonClockUpstreamStrap, coreResetN, eepromInitReq;
    logic masterBusTick, smbusEnable, testDataOut, testDataOeN;
    logic [2:0] switchModeSelect;
    logic [3:0] regAddr, portResetN;
    logic [31:0] regWrData, regRdData;
    logic [15:0] gpioIn, gpioOut, gpioOeN;
    logic [31:0] eeCount = 32'h0;
    int fails = 0;
    int nTests = 0;

    always #20 clk = ~clk;
    always #60 testClk = ~testClk;
    // Every pin has a pull-up, so an undriven pin reads high.
    assign gpioIn = gpioOut | gpioOeN;
    always @(posedge clk) if (eepromInitReq === 1'b1) eeCount <= eeCount + 32'h1;

    srsc_top srsc_top_inst (.clk, .rst, .fundamentalResetN, .holdAfterReset, .switchModeSelect, .masterBusSlowSelect,
        .commonClockDownstreamStrap, .commonClockUpstreamStrap, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
        .gpioIn, .gpioOut, .gpioOeN, .coreResetN, .portResetN, .eepromInitReq, .masterBusTick, .smbusEnable, .testClk,
        .testResetN, .testShiftData, .testShiftActive, .testDataOut, .testDataOeN);
    srsc_board srsc_board_inst (.clk, .fundamentalResetN, .holdAfterReset, .switchModeSelect, .masterBusSlowSelect,
        .commonClockDownstreamStrap, .commonClockUpstreamStrap, .testResetN, .regAddr, .regWrData, .regWrEn, .regRdEn,
        .regRdData);

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmpWord(input string what, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmpBit(input string what, input logic exp, input logic got);
        nTests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
        logic [31:0] d;
        srsc_board_inst.rd(a, d);
        cmpWord(what, exp, d & mask);
    endtask
    function automatic logic [31:0] stat(input logic [2:0] m, input logic slow, input logic run);
        stat = 32'h0;
        stat[srsc_pkg::ST_MODE_LSB +: 3] = m;
        stat[srsc_pkg::ST_SLOW_BIT] = slow;
        stat[srsc_pkg::ST_RUN_BIT] = run;
        stat[srsc_pkg::ST_EEPROM_BIT] = (m == srsc_pkg::MODE_EEPROM);
        stat[srsc_pkg::ST_RSVD_BIT] = (m > srsc_pkg::MODE_EEPROM);
    endfunction
    task automatic boot(input srsc_pkg::srsc_strap_s s);
        int n = 0;
        srsc_board_inst.enter(s);
        repeat (8) @(posedge clk);
        cmpBit("coreResetN", 1'b0, coreResetN);
        cmpWord("portResetN", 32'h0, {28'h0, portResetN});
        srsc_board_inst.leave();
        while (smbusEnable !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 200) begin
                fails++;
                conclude();
            end
        end
        repeat (2) @(posedge clk);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // ------------------------------------------------------------
        // Halted start, register access while halted, release
        // ------------------------------------------------------------
        boot('{srsc_pkg::MODE_EEPROM, 1'b1, 1'b1, 1'b0, 1'b1});
        repeat (20) @(posedge clk);
        cmpBit("coreResetN", 1'b0, coreResetN);
        chk(srsc_pkg::ADDR_STRAP_STATUS, 32'h7f, stat(srsc_pkg::MODE_EEPROM, 1'b1, 1'b0), "status");
        chk(srsc_pkg::ADDR_UP_LINK_STATUS, 32'h1000, 32'h0, "upSlot");
        chk(srsc_pkg::ADDR_DN_LINK_STATUS, 32'h7, 32'h7, "dnSlot");
        cmpWord("eepromReqs", 32'h1, eeCount);
        srsc_board_inst.wr(srsc_pkg::ADDR_SWITCH_CONTROL, 32'h1);
        repeat (4) @(posedge clk);
        cmpBit("coreResetN", 1'b0, coreResetN);
        srsc_board_inst.wr(srsc_pkg::ADDR_SWITCH_CONTROL, 32'h0);
        repeat (2) @(posedge clk);
        #1 cmpWord("portResetN", 32'hf, {28'h0, portResetN});
        srsc_board_inst.wr(srsc_pkg::ADDR_DN_LINK_STATUS, 32'h0);
        chk(srsc_pkg::ADDR_DN_LINK_STATUS, 32'h7, 32'h0, "dnSlot");
        srsc_board_inst.wr(srsc_pkg::ADDR_UP_LINK_STATUS, 32'h1000);
        chk(srsc_pkg::ADDR_UP_LINK_STATUS, 32'h1000, 32'h1000, "upSlot");
        chk(4'hf, 32'hffffffff, 32'h0, "unmapped");
        repeat (300) @(posedge clk);
        chk(srsc_pkg::ADDR_STRAP_STATUS, 32'h7f, stat(srsc_pkg::MODE_EEPROM, 1'b1, 1'b1), "status");
        $display("halt test done");
        // Port resets out on the alternate pins, pin 12 as plain output.
        srsc_board_inst.wr(srsc_pkg::ADDR_GPIO_FUNC, 32'h0803);
        srsc_board_inst.wr(srsc_pkg::ADDR_PORT_RESET, 32'ha);
        srsc_board_inst.wr(srsc_pkg::ADDR_GPIO_DIR, 32'h1000);
        srsc_board_inst.wr(srsc_pkg::ADDR_GPIO_OUT, 32'h1000);
        repeat (8) @(posedge clk);
        cmpWord("portResetN", 32'h5, {28'h0, portResetN});
        cmpWord("gpioOut", 32'h1002, {16'h0, gpioOut & 16'h1803});
        cmpWord("gpioOeN", 32'h0, {16'h0, gpioOeN & 16'h1803});
        chk(srsc_pkg::ADDR_GPIO_IN, 32'h1803, 32'h1002, "gpioIn");
        $display("gpio test done");
        srsc_board_inst.setTest(1'b1);
        testShiftData <= 1'b1;
        testShiftActive <= 1'b1;
        repeat (10) @(posedge clk);
        cmpBit("testDataOeN", 1'b0, testDataOeN);
        cmpBit("testDataOut", 1'b1, testDataOut);
        testShiftActive <= 1'b0;
        repeat (10) @(posedge clk);
        cmpBit("testDataOeN", 1'b1, testDataOeN);
        testShiftActive <= 1'b1;
        repeat (10) @(posedge clk);
        srsc_board_inst.setTest(1'b0);
        #1 cmpBit("testDataOeN", 1'b1, testDataOeN);
        cmpBit("testDataOut", 1'b0, testDataOut);
        testShiftActive <= 1'b0;
        $display("test port done");
        // ------------------------------------------------------------
        // Fundamental reset in mid-run, then the reserved mode codes 2 to 7
        // ------------------------------------------------------------
        boot('{srsc_pkg::MODE_NORMAL, 1'b0, 1'b0, 1'b1, 1'b0});
        cmpBit("coreResetN", 1'b1, coreResetN);
        chk(srsc_pkg::ADDR_GPIO_FUNC, 32'hffff, {16'h0, srsc_pkg::GPIO_FUNC_RESET}, "gpioFunc");
        chk(srsc_pkg::ADDR_STRAP_STATUS, 32'h7f, stat(srsc_pkg::MODE_NORMAL, 1'b0, 1'b1), "status");
        chk(srsc_pkg::ADDR_UP_LINK_STATUS, 32'h1000, 32'h1000, "upSlot");
        chk(srsc_pkg::ADDR_DN_LINK_STATUS, 32'h7, 32'h0, "dnSlot");
        repeat (100) @(posedge clk);
        cmpWord("eepromReqs", 32'h1, eeCount);
        for (int m = 2; m < 8; m++) begin
            boot('{3'(m), m[0], m[1], m[2], 1'b0});
            chk(srsc_pkg::ADDR_STRAP_STATUS, 32'h6f, stat(3'(m), m[0], 1'b0), "status");
            chk(srsc_pkg::ADDR_DN_LINK_STATUS, 32'h7, {29'h0, {3{m[1]}}}, "dnSlot");
        end
        cmpWord("eepromReqs", 32'h1, eeCount);
        $display("mode test done");
        conclude();
    end
endmodule
